// ===== verilog/io_cell_pkg.sv
/*
 * Shared constants for the configurable io cell: APB register offsets,
 * field positions, reset values and driver control codes.
 * Assumes a 32-bit APB slave with byte addresses and one word per register.
 */
package io_cell_pkg;

    // register byte offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] CFG_OFS = 12'h004;
    localparam logic [11:0] LINE_POL_OFS = 12'h008;
    localparam logic [11:0] STATUS_OFS = 12'h00C;

    // control register: configuration phase, readback, global threshold
    localparam int CTRL_W = 3;
    localparam int CTRL_CFG_BIT = 0;
    localparam int CTRL_RB_BIT = 1;
    localparam int CTRL_TTL_BIT = 2;
    localparam logic [2:0] CTRL_RST = 3'h1;

    // per-cell option word
    localparam int CFG_W = 10;
    localparam int CFG_LATCH_BIT = 0;
    localparam int CFG_IN_SEL_BIT = 1;
    localparam int CFG_OUT_REG_BIT = 2;
    localparam int CFG_OUT_INV_BIT = 3;
    localparam int CFG_DRV_LSB = 4;
    localparam int CFG_TINV_BIT = 6;
    localparam int CFG_OUT_SEL_BIT = 7;
    localparam int CFG_FAST_BIT = 8;
    localparam int CFG_PULLUP_BIT = 9;
    localparam logic [9:0] CFG_RST = 10'h000;

    // driver control codes; the unused code behaves as port control
    localparam logic [1:0] DRIVE_PORT = 2'h0;
    localparam logic [1:0] DRIVE_ON = 2'h1;
    localparam logic [1:0] DRIVE_OFF = 2'h2;

    // edge clock line buffer polarity, one bit per line
    localparam int LINE_POL_W = 2;
    localparam logic [1:0] LINE_POL_RST = 2'h0;

    // status register bits
    localparam int ST_DIRECT_BIT = 0;
    localparam int ST_STORED_BIT = 1;
    localparam int ST_OE_BIT = 2;
    localparam int ST_OUT_BIT = 3;
    localparam int ST_OUTREG_BIT = 4;

endpackage : io_cell_pkg

// ===== verilog/two_flop_sync.sv
/*
 * Two-flop synchroniser for a bundle of independent levels.
 * Assumes each bit is a slow level; bits are not coherent with each other.
 */
`timescale 1ns/100ps

module two_flop_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // first stage is read only by the second stage
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule : two_flop_sync

// ===== verilog/edge_line_pick.sv
/*
 * Picks one of the two die edge clock lines, applies that line's buffer
 * polarity and flags its rising edge.
 * Assumes both lines arrive already synchronised to core_clk.
 */
`timescale 1ns/100ps

module edge_line_pick (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic line_a,
    input wire logic line_b,
    input wire logic line_sel,
    input wire logic [1:0] line_pol,
    output logic line_level,
    output logic line_rise
);

    logic prev_ff;

    // polarity belongs to the line, so every cell on it sees one sense
    always_comb
    begin
        line_level = line_sel ? (line_b ^ line_pol[1]) : (line_a ^ line_pol[0]);
    end

    // previous level for edge detection
    always_ff @(posedge core_clk)
    begin
        if (rst)
            prev_ff <= 1'b0;
        else
            prev_ff <= line_level;
    end

    assign line_rise = line_level & ~prev_ff;

endmodule : edge_line_pick

// ===== verilog/configurable_io_cell.sv
/*
 * One configurable io cell between a package pin and the internal logic:
 * input path with direct and stored outputs, output path with optional
 * register, inversion, driver control, slew and pull-up selection, and the
 * APB register file that holds the static options.
 * Assumes pin comparators, edge clock lines and chip reset pin are
 * asynchronous to core_clk; out_data and out_disable come from core_clk logic.
 */
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/100ps

// Functional notes
// RULE_01: input storage is flip-flop or low-transparent latch
// RULE_02: inverted sense per clock line, shared by cells
// RULE_03: input load and output clock pick edge line
// RULE_04: storage cleared in configuration or chip reset
// RULE_05: direct and stored input both presented
// RULE_06: one global bit selects TTL or CMOS
// RULE_07: output data direct or through register
// RULE_08: open drain: drive same signal to both ports
// RULE_09: one bit inverts output data
// RULE_10: driver forced on, forced off, or port controlled
// RULE_11: disable high gives high impedance, low drives
// RULE_12: extra bit inverts disable into enable
// RULE_13: output register captures rising edge of line
// RULE_14: one bit selects fast or limited slew
// RULE_15: one bit enables weak pin pull-up
// RULE_16: options written only in configuration, read in readback
// RULE_17: inner logic may synchronise inputs with flip-flop
// RULE_18: clears override clock edge and latch phase
module configurable_io_cell
    import io_cell_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic chip_reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pad_in_ttl,
    input wire logic pad_in_cmos,
    input wire logic edge_clk_a,
    input wire logic edge_clk_b,
    input wire logic out_data,
    input wire logic out_disable,
    output logic in_direct,
    output logic in_stored,
    output logic pad_out,
    output logic pad_oe,
    output logic pad_slew_fast,
    output logic pad_pullup_en
);

    logic [4:0] pin_s;
    logic ttl_s;
    logic cmos_s;
    logic line_a_s;
    logic line_b_s;
    logic chip_reset_n_s;
    logic [CTRL_W-1:0] ctrl_ff;
    logic [CFG_W-1:0] cfg_ff;
    logic [LINE_POL_W-1:0] line_pol_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic [31:0] rd_mux;
    logic addr_hit;
    logic wr_locked;
    logic apb_access;
    logic apb_first;
    logic apb_done;
    logic cfg_mode;
    logic clr;
    logic din;
    logic in_level;
    logic in_rise;
    logic out_level;
    logic out_rise;
    logic in_stored_ff;
    logic in_direct_ff;
    logic out_reg_ff;
    logic pad_out_ff;
    logic pad_oe_ff;
    logic slew_ff;
    logic pullup_ff;
    logic t_eff;
    logic drive_on;
    logic [1:0] drive_mode;
    logic [ADDR_W-1:0] word_addr;

    // every pin-side level passes two flops before any logic sees it
    two_flop_sync #(
        .WIDTH(5)
    ) u_pin_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in({chip_reset_n, edge_clk_b, edge_clk_a, pad_in_cmos, pad_in_ttl}),
        .sync_out(pin_s)
    );

    assign ttl_s = pin_s[0];
    assign cmos_s = pin_s[1];
    assign line_a_s = pin_s[2];
    assign line_b_s = pin_s[3];
    // sync flops reset to zero, so chip reset reads as asserted until released
    assign chip_reset_n_s = pin_s[4];

    assign cfg_mode = ctrl_ff[CTRL_CFG_BIT];
    assign drive_mode = cfg_ff[CFG_DRV_LSB +: 2];

    // storage clear: configuration phase or chip reset
    assign clr = cfg_mode | ~chip_reset_n_s; // [RULE_04]

    // one global threshold choice for the whole cell input
    assign din = ctrl_ff[CTRL_TTL_BIT] ? ttl_s : cmos_s; // [RULE_06]

    // input load clock line choice
    edge_line_pick u_in_load_clock (
        .core_clk(core_clk),
        .rst(rst),
        .line_a(line_a_s),
        .line_b(line_b_s),
        .line_sel(cfg_ff[CFG_IN_SEL_BIT]), // [RULE_03]
        .line_pol(line_pol_ff), // [RULE_02]
        .line_level(in_level),
        .line_rise(in_rise)
    );

    // output clock line choice, through the same invertible line buffers
    edge_line_pick u_out_clock (
        .core_clk(core_clk),
        .rst(rst),
        .line_a(line_a_s),
        .line_b(line_b_s),
        .line_sel(cfg_ff[CFG_OUT_SEL_BIT]), // [RULE_03]
        .line_pol(line_pol_ff),
        .line_level(out_level),
        .line_rise(out_rise)
    );

    // input storage element; clear wins over any edge or latch phase
    always_ff @(posedge core_clk)
    begin
        if (rst || clr)
            in_stored_ff <= 1'b0; // [RULE_18]
        else if (cfg_ff[CFG_LATCH_BIT])
        begin
            if (!in_level)
                in_stored_ff <= din; // [RULE_01]
        end
        else if (in_rise)
            in_stored_ff <= din; // [RULE_01]
    end

    // output register, rising edge of the polarised line
    always_ff @(posedge core_clk)
    begin
        if (rst || clr)
            out_reg_ff <= 1'b0; // [RULE_18]
        else if (out_rise)
            out_reg_ff <= out_data; // [RULE_13]
    end

    // direct input mirror; both paths leave the cell together
    always_ff @(posedge core_clk)
    begin
        if (rst)
            in_direct_ff <= 1'b0;
        else
            in_direct_ff <= din; // [RULE_05]
    end

    // driver control; open drain comes from tying data and disable together
    always_comb
    begin
        t_eff = out_disable ^ cfg_ff[CFG_TINV_BIT]; // [RULE_12]
        case (drive_mode)
            DRIVE_ON: drive_on = 1'b1; // [RULE_10]
            DRIVE_OFF: drive_on = 1'b0; // [RULE_10]
            default: drive_on = ~t_eff; // [RULE_11]
        endcase
    end

    // pad outputs, registered so the pin never sees a glitch from the mux
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pad_out_ff <= 1'b0;
            pad_oe_ff <= 1'b0;
            slew_ff <= 1'b0;
            pullup_ff <= 1'b0;
        end
        else
        begin
            pad_out_ff <= (cfg_ff[CFG_OUT_REG_BIT] ? out_reg_ff : out_data) // [RULE_07]
                          ^ cfg_ff[CFG_OUT_INV_BIT]; // [RULE_09]
            pad_oe_ff <= drive_on;
            slew_ff <= cfg_ff[CFG_FAST_BIT]; // [RULE_14]
            pullup_ff <= cfg_ff[CFG_PULLUP_BIT]; // [RULE_15]
        end
    end

    // APB decode; one wait state, so the answer comes on the second access cycle
    assign apb_access = psel & penable;
    assign apb_first = apb_access & ~pready_ff;
    assign apb_done = apb_access & pready_ff;
    assign word_addr = {paddr[ADDR_W-1:2], 2'h0};
    assign addr_hit = (paddr[1:0] == 2'h0) &&
                      ((word_addr == ADDR_W'(CTRL_OFS)) || (word_addr == ADDR_W'(CFG_OFS)) ||
                       (word_addr == ADDR_W'(LINE_POL_OFS)) || (word_addr == ADDR_W'(STATUS_OFS)));
    // option words are frozen outside configuration; status is read only
    assign wr_locked = pwrite && ((word_addr == ADDR_W'(STATUS_OFS)) ||
                       (!cfg_mode && ((word_addr == ADDR_W'(CFG_OFS)) ||
                                      (word_addr == ADDR_W'(LINE_POL_OFS)))));

    // read mux; option words read back only while readback is on
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (word_addr == ADDR_W'(CTRL_OFS))
            rd_mux[CTRL_W-1:0] = ctrl_ff;
        else if (word_addr == ADDR_W'(CFG_OFS) && ctrl_ff[CTRL_RB_BIT])
            rd_mux[CFG_W-1:0] = cfg_ff; // [RULE_16]
        else if (word_addr == ADDR_W'(LINE_POL_OFS) && ctrl_ff[CTRL_RB_BIT])
            rd_mux[LINE_POL_W-1:0] = line_pol_ff; // [RULE_16]
        else if (word_addr == ADDR_W'(STATUS_OFS))
        begin
            rd_mux[ST_DIRECT_BIT] = in_direct_ff;
            rd_mux[ST_STORED_BIT] = in_stored_ff;
            rd_mux[ST_OE_BIT] = pad_oe_ff;
            rd_mux[ST_OUT_BIT] = pad_out_ff;
            rd_mux[ST_OUTREG_BIT] = out_reg_ff;
        end
    end

    // APB answer: pready, read data and error all set together
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end
        else
        begin
            pready_ff <= apb_first;
            pslverr_ff <= apb_first & (~addr_hit | wr_locked);
            prdata_ff <= (apb_first && !pwrite && addr_hit) ? rd_mux : 32'h0000_0000;
        end
    end

    // control register, writable at any time
    always_ff @(posedge core_clk)
    begin
        if (rst)
            ctrl_ff <= CTRL_RST;
        else if (apb_done && pwrite && !pslverr_ff && word_addr == ADDR_W'(CTRL_OFS))
            ctrl_ff <= pwdata[CTRL_W-1:0];
    end

    // option registers, written only during configuration
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cfg_ff <= CFG_RST;
            line_pol_ff <= LINE_POL_RST;
        end
        else if (apb_done && pwrite && !pslverr_ff && cfg_mode) // [RULE_16]
        begin
            if (word_addr == ADDR_W'(CFG_OFS))
                cfg_ff <= pwdata[CFG_W-1:0];
            if (word_addr == ADDR_W'(LINE_POL_OFS))
                line_pol_ff <= pwdata[LINE_POL_W-1:0];
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign in_direct = in_direct_ff;
    assign in_stored = in_stored_ff;
    assign pad_out = pad_out_ff;
    assign pad_oe = pad_oe_ff;
    assign pad_slew_fast = slew_ff;
    assign pad_pullup_en = pullup_ff;

    // checks on the cell behaviour
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    AST_LATCH_OPEN: assert property ( // [RULE_01]
        cfg_ff[CFG_LATCH_BIT] && !in_level && !clr |=> in_stored_ff == $past(din))
        else $error("latch not transparent while load low");

    AST_FF_HOLDS: assert property ( // [RULE_01]
        !cfg_ff[CFG_LATCH_BIT] && !in_rise && !clr |=> $stable(in_stored_ff))
        else $error("input flip-flop changed without a load edge");

    AST_FF_CAPTURE: assert property ( // [RULE_01]
        !cfg_ff[CFG_LATCH_BIT] && in_rise && !clr |=> in_stored_ff == $past(din))
        else $error("input flip-flop missed its load edge");

    AST_CLEAR: assert property ( // [RULE_04]
        clr |=> !in_stored_ff && !out_reg_ff)
        else $error("storage not cleared");

    AST_OUT_CAPTURE: assert property ( // [RULE_13]
        out_rise && !clr |=> out_reg_ff == $past(out_data))
        else $error("output register missed its clock edge");

    AST_PAD_DATA: assert property ( // [RULE_09]
        !cfg_ff[CFG_OUT_REG_BIT] && $stable(cfg_ff)
        |=> pad_out_ff == ($past(out_data) ^ $past(cfg_ff[CFG_OUT_INV_BIT])))
        else $error("pad data not direct output with inversion");

    AST_FORCED_DRIVE: assert property ( // [RULE_10]
        drive_mode == DRIVE_OFF ##1 drive_mode == DRIVE_OFF |-> !pad_oe_ff)
        else $error("driver on while forced off");

    AST_DISABLE_PORT: assert property ( // [RULE_11]
        drive_mode == DRIVE_PORT && (out_disable ^ cfg_ff[CFG_TINV_BIT]) |=> !pad_oe_ff)
        else $error("driver on while disable asserted");

    AST_CFG_LOCK: assert property ( // [RULE_16]
        !cfg_mode && apb_done && pwrite |=> $stable(cfg_ff) && $stable(line_pol_ff))
        else $error("options changed outside configuration");

    AST_APB_ANSWER: assert property (
        apb_first |=> pready_ff ##1 !pready_ff)
        else $error("apb answer not one cycle after access start");

    AST_PAD_STATIC: assert property ( // [RULE_15]
        $stable(cfg_ff) [*2] |-> pullup_ff == cfg_ff[CFG_PULLUP_BIT]
                                && slew_ff == cfg_ff[CFG_FAST_BIT]) // [RULE_14]
        else $error("pull-up or slew does not follow options");

    AST_COV_LATCH: cover property (cfg_ff[CFG_LATCH_BIT] && !in_level && din && !clr);
    AST_COV_FF: cover property (!cfg_ff[CFG_LATCH_BIT] && in_rise && !clr ##1 in_stored_ff);
    AST_COV_OPEN_DRAIN: cover property (drive_mode == DRIVE_PORT && out_data == out_disable
                                        && !out_data ##1 pad_oe_ff); // [RULE_08]

endmodule : configurable_io_cell

// ===== verif/pin_board_model.sv
/*
 * Board side of one package pin: an external driver with three voltage
 * levels, the cell's own driver and its weak pull-up, and the two
 * threshold comparators that turn the pin voltage back into logic.
 * Assumes the bench drives board_* off the clock edge and releases the
 * board driver whenever the cell is meant to drive the pin.
 */
`timescale 1ns/100ps

module pin_board_model (
    input wire logic core_clk,
    input wire logic pad_out,
    input wire logic pad_oe,
    input wire logic pad_pullup_en,
    input wire logic board_drive_en,
    input wire logic [1:0] board_level,
    output logic pin_level,
    output logic pad_in_ttl,
    output logic pad_in_cmos
);
    // voltage code: 0 low, 1 between the thresholds, 2 high
    logic [1:0] volt;
    logic float_ff;

    // an unheld pin wanders, so no stale value survives a release
    always @(posedge core_clk)
    begin
        float_ff <= ~float_ff;
    end

    initial float_ff = 1'b0;

    // cell driver wins, then the board, then the pull-up
    always_comb
    begin
        if (pad_oe)
            volt = pad_out ? 2'h2 : 2'h0;
        else if (board_drive_en)
            volt = board_level;
        else if (pad_pullup_en)
            volt = 2'h2;
        else
            volt = float_ff ? 2'h2 : 2'h0;
    end

    // a mid voltage reads high only against the lower threshold
    assign pad_in_ttl = (volt != 2'h0);
    assign pad_in_cmos = (volt == 2'h2);
    assign pin_level = volt[1];
endmodule : pin_board_model

// ===== verif/tb_top.sv
/*
 * Self-checking bench for the configurable io cell: APB master tasks,
 * a pin model at the pad, and directed sequences over every option.
 * Assumes the hand-over timing: pins reach in_direct three edges on,
 * outputs follow their inputs one edge on.
 */
`timescale 1ns/100ps

module tb_top;
    import io_cell_pkg::*;

    logic core_clk, rst, chip_reset_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pad_in_ttl, pad_in_cmos, edge_clk_a, edge_clk_b, out_data, out_disable;
    logic in_direct, in_stored, pad_out, pad_oe, pad_slew_fast, pad_pullup_en;
    logic board_drive_en, pin_level, err, exp_oe;
    logic [1:0] board_level, drv;
    logic [4:0] v;
    int error_cnt, num_checks;

    configurable_io_cell #(.ADDR_W(12)) u_dut (.core_clk(core_clk), .rst(rst),
        .chip_reset_n(chip_reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pad_in_ttl(pad_in_ttl), .pad_in_cmos(pad_in_cmos),
        .edge_clk_a(edge_clk_a), .edge_clk_b(edge_clk_b), .out_data(out_data),
        .out_disable(out_disable), .in_direct(in_direct), .in_stored(in_stored),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_slew_fast(pad_slew_fast),
        .pad_pullup_en(pad_pullup_en));

    pin_board_model u_pin (.core_clk(core_clk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup_en(pad_pullup_en), .board_drive_en(board_drive_en),
        .board_level(board_level), .pin_level(pin_level), .pad_in_ttl(pad_in_ttl),
        .pad_in_cmos(pad_in_cmos));

    // 10 MHz core clock
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task conclude;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask : idle

    // one APB transfer; the request stands until pready is sampled high
    task apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do
        begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // options may only change inside a configuration phase
    task setup(input logic [9:0] c, input logic [1:0] pol, input logic [2:0] ctrl);
        apb(CTRL_OFS, 1'b1, 32'h0000_0001);
        apb(CFG_OFS, 1'b1, {22'h0, c});
        apb(LINE_POL_OFS, 1'b1, {30'h0, pol});
        apb(CTRL_OFS, 1'b1, {29'h0, ctrl});
    endtask : setup

    // hang guard, far beyond the roughly one thousand cycles the sequence needs
    initial
    begin
        #2000000;
        error_cnt++;
        conclude();
    end

    initial
    begin
        {rst, psel, penable, pwrite, edge_clk_a, edge_clk_b} = 6'h01 << 5;
        {out_data, out_disable, board_drive_en} = 3'h0;
        chip_reset_n = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0;
        board_level = 2'h0;
        error_cnt = 0;
        num_checks = 0;
        idle(4);
        rst <= 1'b0;
        idle(3);
        // reset values, access kinds and refusals
        apb(CTRL_OFS, 1'b0, 32'h0);
        check(rd, {29'h0, CTRL_RST});
        apb(CTRL_OFS, 1'b1, 32'h0000_0003);
        apb(CFG_OFS, 1'b0, 32'h0);
        check(rd, {22'h0, CFG_RST});
        apb(LINE_POL_OFS, 1'b0, 32'h0);
        check(rd, {30'h0, LINE_POL_RST});
        apb(CFG_OFS, 1'b1, 32'h0000_03FF);
        check(err, 1'b0);
        apb(CTRL_OFS, 1'b1, 32'h0000_0000);
        apb(CFG_OFS, 1'b0, 32'h0);
        check(rd, 32'h0);
        apb(CFG_OFS, 1'b1, 32'h0000_0000);
        check(err, 1'b1);
        apb(CTRL_OFS, 1'b1, 32'h0000_0002);
        apb(CFG_OFS, 1'b0, 32'h0);
        check(rd, 32'h0000_03FF);
        apb(STATUS_OFS, 1'b1, 32'h0);
        check(err, 1'b1);
        apb(12'h010, 1'b0, 32'h0);
        check(err, 1'b1);
        // threshold choice with a pin sitting between the two levels
        board_drive_en <= 1'b1;
        board_level <= 2'h1;
        setup(10'h020, 2'h0, 3'h4);
        idle(6);
        check(in_direct, 1'b1);
        apb(CTRL_OFS, 1'b1, 32'h0000_0000);
        idle(6);
        check(in_direct, 1'b0);
        // every driver code, disable sense, inversion, slew and pull-up
        board_drive_en <= 1'b0;
        for (int i = 0; i < 32; i++)
        begin
            v = i[4:0];
            drv = v[1:0];
            out_data <= v[4];
            out_disable <= v[3];
            setup({v[0], v[2], 1'b0, v[2], drv, v[3] ^ v[1], 3'h0}, 2'h0, 3'h0);
            idle(6);
            exp_oe = (drv == DRIVE_ON) ? 1'b1 : (drv == DRIVE_OFF) ? 1'b0 : ~(v[3] ^ v[2]);
            check(pad_oe, exp_oe);
            check(pad_out, v[4] ^ v[3] ^ v[1]);
            check(pad_slew_fast, v[2]);
            check(pad_pullup_en, v[0]);
            if (!exp_oe && v[0])
            begin
                check(in_direct, 1'b1);
                check(pin_level, 1'b1);
            end
        end
        // output register on line b through an inverting buffer
        setup(10'h094, 2'h2, 3'h0);
        out_data <= 1'b1;
        idle(6);
        check(pad_out, 1'b0);
        edge_clk_b <= 1'b1;
        idle(6);
        check(pad_out, 1'b0);
        edge_clk_b <= 1'b0;
        idle(6);
        check(pad_out, 1'b1);
        out_data <= 1'b0;
        idle(6);
        check(pad_out, 1'b1);
        chip_reset_n <= 1'b0;
        // two sync edges, the clear, then the pad register one edge later
        idle(6);
        check(pad_out, 1'b0);
        chip_reset_n <= 1'b1;
        // input flip-flop loaded from line b only
        board_drive_en <= 1'b1;
        board_level <= 2'h2;
        setup(10'h022, 2'h0, 3'h0);
        idle(6);
        check(in_stored, 1'b0);
        edge_clk_a <= 1'b1;
        idle(6);
        check(in_stored, 1'b0);
        edge_clk_b <= 1'b1;
        idle(6);
        check(in_stored, 1'b1);
        board_level <= 2'h0;
        idle(6);
        check(in_direct, 1'b0);
        check(in_stored, 1'b1);
        apb(STATUS_OFS, 1'b0, 32'h0);
        check(rd & 32'h0000_0007, 32'h0000_0002);
        chip_reset_n <= 1'b0;
        idle(4);
        check(in_stored, 1'b0);
        chip_reset_n <= 1'b1;
        // latch on line a: transparent low, opaque high, then inverted sense
        edge_clk_a <= 1'b0;
        board_level <= 2'h2;
        setup(10'h021, 2'h0, 3'h0);
        idle(6);
        check(in_stored, 1'b1);
        edge_clk_a <= 1'b1;
        idle(6);
        board_level <= 2'h0;
        idle(6);
        check(in_stored, 1'b1);
        setup(10'h021, 2'h1, 3'h0);
        board_level <= 2'h2;
        idle(6);
        check(in_stored, 1'b1);
        conclude();
    end
endmodule : tb_top
